// ==== pkg/spz_map.svh ====
// register indices, field positions and counts of the serial port
`ifndef SPZ_MAP_SVH
`define SPZ_MAP_SVH
`define SPZ_IDX_CTRL 8'h98
`define SPZ_IDX_DATA 8'h99
`define SPZ_IDX_AUX 8'h9a
`define SPZ_B_SM0 7
`define SPZ_B_SM1 6
`define SPZ_B_SM2 5
`define SPZ_B_REN 4
`define SPZ_B_TB8 3
`define SPZ_B_RB8 2
`define SPZ_B_TI 1
`define SPZ_B_RI 0
`define SPZ_A_DBL 0
`define SPZ_A_RXT2 1
`define SPZ_A_TXT2 2
`define SPZ_MODE_SYNC 2'h0
`define SPZ_MODE_FIX9 2'h2
`define SPZ_M0_FALL 4'h6
`define SPZ_M0_LAST 4'hb
`define SPZ_OS_MID 4'h7
`define SPZ_OS_LAST 4'hf
`define SPZ_FIX_LAST 2'h3
`define SPZ_BITS_M0 4'h8
`define SPZ_TXBITS_8 4'ha
`define SPZ_TXBITS_9 4'hb
`define SPZ_RXBITS_8 4'h9
`define SPZ_RXBITS_9 4'ha
`define SPZ_BITS_END 4'h1
`endif

// ==== pkg/spz_pkg.sv ====
// types of the serial port
package spz_pkg;
  typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} spz_txst_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} spz_rxst_t;
  typedef struct packed {
    logic [1:0] mode;
    logic mpEn;
    logic ren;
    logic tb8;
    logic rb8;
    logic ti;
    logic ri;
    logic doubler;
    logic rxT2;
    logic txT2;
    logic [7:0] rxHold;
    logic ack;
    logic [7:0] rdData;
    logic [2:0] inSync;
    logic t1Half;
    logic [1:0] fixDiv;
    spz_txst_t txSt;
    logic [10:0] txShift;
    logic [3:0] txBits;
    logic [3:0] txTicks;
    logic m0Rx;
    logic [3:0] m0Ph;
    spz_rxst_t rxSt;
    logic [9:0] rxShift;
    logic [3:0] rxBits;
    logic [3:0] rxTicks;
    logic outLow;
    logic dDrv;
    logic wake;
  } spz_state_t;
endpackage : spz_pkg

// ==== core/spz_serial_port.sv ====
// four-mode serial port with wishbone register access
//
// Operation
// - receiver double-buffered, shifter separate from holding register
// - data write loads transmitter, read returns receiver
// - mode bits select shift, 8-bit, fixed 9-bit, timed 9-bit
// - ninth bit one is address, zero data
// - multiprocessor enable drops data bytes, keeps addresses
// - receive enable lets input edges end slow power
// - 9-bit modes send software ninth bit
// - 9-bit modes capture received ninth bit
// - transmit done set by hardware, software clears
// - receive done set by hardware, software clears
// - data write starts transmission in current mode
// - shift mode: out pin clocks, in pin data
// - shift data changes rising, sampled falling edge
// - shift transmit starts with done flag clear
// - shift receive starts with enable, flag clear
// - 8-bit frame: start, eight data, stop
// - timer 1 rate, halved when doubler clear
// - timer 2 select overrides per direction
// - 9-bit frame: start, eight, ninth, stop
// - fixed mode: clock over 64 or 32
// - timed 9-bit mode selects rate like 8-bit
// - no parity checking in hardware
`include "spz_map.svh"
`timescale 1ns/1ps
`default_nettype none
module spz_serial_port (
  input wire logic clk, // processor clock, 10 MHz
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic clkEn, // freezes all state while low
  input wire logic wbCyc, // wishbone cycle
  input wire logic wbStb, // wishbone strobe
  input wire logic wbWe, // wishbone write enable
  input wire logic [9:0] wbAdr, // wishbone byte address
  input wire logic [3:0] wbSel, // wishbone byte selects
  input wire logic [31:0] wbDatW, // wishbone write data
  output logic [31:0] wbDatR, // wishbone read data
  output logic wbAck, // wishbone acknowledge
  input wire logic timer1Ovf, // timer 1 overflow pulse
  input wire logic timer2Ovf, // timer 2 overflow pulse
  input wire logic slowPowerMode, // slow power mode active
  output logic wakeReq, // pulse: leave slow power mode
  output logic serialOutPin, // serial out or shift clock
  input wire logic serialInPin, // serial in pin level
  output logic serialInOut, // serial in pin drive value
  output logic serialInOe // serial in pin drive enable
);

  ////////////////////////////////////////////////////////////////////
  spz_pkg::spz_state_t s;
  spz_pkg::spz_state_t next_s;
  logic busReq;
  logic wr;
  logic rd;
  logic [7:0] idx;
  logic sIn;
  logic prevIn;
  logic fixTick;
  logic t1Tick;
  logic txTick;
  logic rxTick;
  logic isSync;

  assign busReq = wbCyc & wbStb & ~s.ack;
  assign wr = busReq & wbWe & wbSel[0];
  assign rd = busReq & ~wbWe;
  assign idx = wbAdr[9:2];
  assign sIn = s.inSync[1];
  assign prevIn = s.inSync[2];
  assign isSync = s.mode == `SPZ_MODE_SYNC;
  // fixed rate: 16 ticks per bit, one tick per 2 or 4 clocks
  assign fixTick = s.doubler ? s.fixDiv[0] : (s.fixDiv == `SPZ_FIX_LAST);
  assign t1Tick = timer1Ovf & (s.doubler | s.t1Half);
  assign rxTick = (s.mode == `SPZ_MODE_FIX9) ? fixTick :
                  (s.rxT2 ? timer2Ovf : t1Tick);
  assign txTick = (s.mode == `SPZ_MODE_FIX9) ? fixTick :
                  (s.txT2 ? timer2Ovf : t1Tick);

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [9:0] sh;
    logic [7:0] rxData;
    logic ninth;
    sh = {sIn, s.rxShift[9:1]};
    rxData = s.mode[1] ? sh[7:0] : sh[8:1];
    ninth = s.mode[1] ? sh[8] : sh[9];
    next_s = s;
    next_s.ack = busReq;
    next_s.inSync = {s.inSync[1], s.inSync[0], serialInPin};
    next_s.fixDiv = s.fixDiv + 2'h1;
    if (timer1Ovf) begin
      next_s.t1Half = ~s.t1Half;
    end
    // register reads
    next_s.rdData = 8'h00;
    if (rd) begin
      unique case (idx)
        `SPZ_IDX_CTRL: next_s.rdData = {s.mode, s.mpEn, s.ren, s.tb8,
                                        s.rb8, s.ti, s.ri};
        `SPZ_IDX_DATA: next_s.rdData = s.rxHold;
        `SPZ_IDX_AUX: next_s.rdData = {3'h0, s.rxSt != spz_pkg::RX_IDLE,
                                       s.txSt == spz_pkg::TX_SHIFT, s.txT2,
                                       s.rxT2, s.doubler};
        default: next_s.rdData = 8'h00;
      endcase
    end
    // register writes; hardware sets below win over these
    if (wr && idx == `SPZ_IDX_CTRL) begin
      next_s.mode = {wbDatW[`SPZ_B_SM0], wbDatW[`SPZ_B_SM1]};
      next_s.mpEn = wbDatW[`SPZ_B_SM2];
      next_s.ren = wbDatW[`SPZ_B_REN];
      next_s.tb8 = wbDatW[`SPZ_B_TB8];
      next_s.rb8 = wbDatW[`SPZ_B_RB8];
      next_s.ti = wbDatW[`SPZ_B_TI];
      next_s.ri = wbDatW[`SPZ_B_RI];
    end
    if (wr && idx == `SPZ_IDX_AUX) begin
      next_s.doubler = wbDatW[`SPZ_A_DBL];
      next_s.rxT2 = wbDatW[`SPZ_A_RXT2];
      next_s.txT2 = wbDatW[`SPZ_A_TXT2];
    end
    // data write starts a transmission when the transmitter is idle, in shift mode only with ti clear
    if (wr && idx == `SPZ_IDX_DATA && s.txSt == spz_pkg::TX_IDLE) begin
      if (isSync) begin
        if (!s.ti) begin
          next_s.txSt = spz_pkg::TX_SHIFT;
          next_s.m0Rx = 1'b0;
          next_s.m0Ph = 4'h0;
          next_s.txBits = `SPZ_BITS_M0;
          next_s.txShift = {3'h7, wbDatW[7:0]};
        end
      end else begin
        next_s.txSt = spz_pkg::TX_SHIFT;
        next_s.txTicks = 4'h0;
        next_s.txBits = s.mode[1] ? `SPZ_TXBITS_9 : `SPZ_TXBITS_8;
        // stop, ninth (or spare stop), data, start
        next_s.txShift = {1'b1, s.mode[1] ? s.tb8 : 1'b1,
                          wbDatW[7:0], 1'b0};
      end
    end else if (isSync && s.txSt == spz_pkg::TX_IDLE && s.ren &&
                 !next_s.ri) begin
      next_s.txSt = spz_pkg::TX_SHIFT;
      next_s.m0Rx = 1'b1;
      next_s.m0Ph = 4'h0;
      next_s.txBits = `SPZ_BITS_M0;
    end
    // shift mode engine, twelve clocks per bit
    if (isSync && s.txSt == spz_pkg::TX_SHIFT) begin
      next_s.m0Ph = (s.m0Ph == `SPZ_M0_LAST) ? 4'h0 : s.m0Ph + 4'h1;
      if (s.m0Rx && s.m0Ph == `SPZ_M0_FALL) begin
        next_s.rxShift = {s.rxShift[9:8], sIn, s.rxShift[7:1]};
      end
      if (s.m0Ph == `SPZ_M0_LAST) begin
        next_s.txShift = {1'b1, s.txShift[10:1]};
        next_s.txBits = s.txBits - 4'h1;
        if (s.txBits == `SPZ_BITS_END) begin
          next_s.txSt = spz_pkg::TX_IDLE;
          if (s.m0Rx) begin
            next_s.rxHold = s.rxShift[7:0];
            next_s.ri = 1'b1;
          end else begin
            next_s.ti = 1'b1;
          end
        end
      end
    end
    // asynchronous transmitter
    if (!isSync && s.txSt == spz_pkg::TX_SHIFT && txTick) begin
      next_s.txTicks = s.txTicks + 4'h1;
      if (s.txTicks == `SPZ_OS_LAST) begin
        next_s.txShift = {1'b1, s.txShift[10:1]};
        next_s.txBits = s.txBits - 4'h1;
        if (s.txBits == `SPZ_BITS_END) begin
          next_s.txSt = spz_pkg::TX_IDLE;
          next_s.ti = 1'b1;
        end
      end
    end
    // asynchronous receiver; the shifter runs while rxHold waits
    unique case (s.rxSt)
      spz_pkg::RX_IDLE: begin
        if (!isSync && s.ren && prevIn && !sIn) begin
          next_s.rxSt = spz_pkg::RX_START;
          next_s.rxTicks = 4'h0;
        end
      end
      spz_pkg::RX_START: begin
        if (rxTick) begin
          next_s.rxTicks = s.rxTicks + 4'h1;
          if (s.rxTicks == `SPZ_OS_MID) begin
            next_s.rxTicks = 4'h0;
            // a high level at mid start bit is a glitch
            next_s.rxSt = sIn ? spz_pkg::RX_IDLE : spz_pkg::RX_BITS;
            next_s.rxBits = s.mode[1] ? `SPZ_RXBITS_9 : `SPZ_RXBITS_8;
          end
        end
      end
      spz_pkg::RX_BITS: begin
        if (rxTick) begin
          next_s.rxTicks = s.rxTicks + 4'h1;
          if (s.rxTicks == `SPZ_OS_LAST) begin
            next_s.rxShift = sh;
            next_s.rxBits = s.rxBits - 4'h1;
            if (s.rxBits == `SPZ_BITS_END) begin
              next_s.rxSt = spz_pkg::RX_IDLE;
              // ninth bit is kept as data, parity is software's job
              if (!next_s.ri && (!s.mpEn || ninth)) begin
                next_s.rxHold = rxData;
                next_s.rb8 = ninth;
                next_s.ri = 1'b1;
              end
            end
          end
        end
      end
    endcase
    if (isSync || !s.ren) begin
      if (s.rxSt != spz_pkg::RX_IDLE) begin
        next_s.rxSt = spz_pkg::RX_IDLE;
      end
    end
    next_s.wake = slowPowerMode & s.ren & (sIn ^ prevIn);
    // pins, registered from the next state
    if (next_s.txSt == spz_pkg::TX_SHIFT) begin
      next_s.outLow = isSync ? next_s.m0Ph >= `SPZ_M0_FALL
                             : ~next_s.txShift[0];
    end else begin
      next_s.outLow = 1'b0;
    end
    next_s.dDrv = isSync && next_s.txSt == spz_pkg::TX_SHIFT &&
                  !next_s.m0Rx && !next_s.txShift[0];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else if (clkEn) begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  assign wbDatR = {24'h0, s.rdData};
  assign wbAck = s.ack;
  assign wakeReq = s.wake;
  assign serialOutPin = ~s.outLow;
  assign serialInOut = 1'b0;
  assign serialInOe = s.dDrv;

  ////////////////////////////////////////////////////////////////////
  a_data_read_path: assert property (
    @(posedge clk) disable iff (!arst_n)
    (clkEn && rd && idx == `SPZ_IDX_DATA) |=>
      (wbAck && wbDatR[7:0] == $past(s.rxHold)))
    else $error("data read does not return receive register");

  a_tx_done_sticky: assert property (
    @(posedge clk) disable iff (!arst_n)
    (s.ti && !(wr && idx == `SPZ_IDX_CTRL)) |=> s.ti)
    else $error("transmit done cleared without software");

  a_rx_done_sticky: assert property (
    @(posedge clk) disable iff (!arst_n)
    (s.ri && !(wr && idx == `SPZ_IDX_CTRL)) |=> s.ri)
    else $error("receive done cleared without software");

  a_mp_filter: assert property (
    @(posedge clk) disable iff (!arst_n)
    ($rose(s.ri) && !$past(wr && idx == `SPZ_IDX_CTRL) &&
     $past(s.mpEn) && !$past(isSync)) |-> s.rb8)
    else $error("data byte raised receive done under multiprocessor");

  a_tx_start: assert property (
    @(posedge clk) disable iff (!arst_n)
    (clkEn && wr && idx == `SPZ_IDX_DATA && !isSync &&
     s.txSt == spz_pkg::TX_IDLE) |=> s.txSt == spz_pkg::TX_SHIFT)
    else $error("data write did not start transmission");

  a_frame_length: assert property (
    @(posedge clk) disable iff (!arst_n)
    ($rose(s.txSt == spz_pkg::TX_SHIFT) && !isSync) |->
      s.txBits == (s.mode[1] ? `SPZ_TXBITS_9 : `SPZ_TXBITS_8))
    else $error("frame length wrong for mode");

  a_shift_clock_fall: assert property (
    @(posedge clk) disable iff (!arst_n)
    ($fell(serialOutPin) && isSync) |->
      (s.m0Ph == `SPZ_M0_FALL && s.txSt == spz_pkg::TX_SHIFT))
    else $error("shift clock fell at wrong phase");

  a_wake_edge: assert property (
    @(posedge clk) disable iff (!arst_n)
    (clkEn && slowPowerMode && s.ren && (sIn != prevIn)) |=> wakeReq)
    else $error("input edge did not request wake");

  a_wake_gated: assert property (
    @(posedge clk) disable iff (!arst_n)
    (clkEn && !s.ren) |=> !wakeReq)
    else $error("wake requested with receive disabled");

  a_ack_one_cycle: assert property (
    @(posedge clk) disable iff (!arst_n)
    (clkEn && wbAck) |=> !wbAck)
    else $error("acknowledge stood longer than one cycle");

  a_ack_answer: assert property (
    @(posedge clk) disable iff (!arst_n)
    (clkEn && wbCyc && wbStb && !wbAck) |=> wbAck)
    else $error("bus request not answered in one cycle");

  a_rx_ninth_capture: assert property (
    @(posedge clk) disable iff (!arst_n)
    ($rose(s.ri) && $past(s.rxSt == spz_pkg::RX_BITS) && $past(s.mode[1]) &&
     !$past(wr && idx == `SPZ_IDX_CTRL)) |->
      (s.rb8 == s.rxShift[8] && s.rxHold == s.rxShift[7:0]))
    else $error("ninth bit or data byte not captured");

  a_rx_stop_kept: assert property (
    @(posedge clk) disable iff (!arst_n)
    ($rose(s.ri) && $past(s.rxSt == spz_pkg::RX_BITS) && !$past(s.mode[1]) &&
     !$past(isSync) && !$past(wr && idx == `SPZ_IDX_CTRL)) |->
      (s.rb8 == s.rxShift[9] && s.rxHold == s.rxShift[8:1]))
    else $error("stop bit or data byte not captured");

  a_rx_hold_kept: assert property (
    @(posedge clk) disable iff (!arst_n)
    (clkEn && s.ri && !isSync && !(wr && idx == `SPZ_IDX_CTRL)) |=>
      $stable(s.rxHold))
    else $error("unread receive byte overwritten");

  a_tx_start_bit: assert property (
    @(posedge clk) disable iff (!arst_n)
    ($rose(s.txSt == spz_pkg::TX_SHIFT) && !isSync) |->
      (!s.txShift[0] && s.txShift[10]))
    else $error("frame lacks start or stop bit");

  a_ninth_sent: assert property (
    @(posedge clk) disable iff (!arst_n)
    ($rose(s.txSt == spz_pkg::TX_SHIFT) && s.mode[1]) |->
      s.txShift[9] == $past(s.tb8))
    else $error("ninth bit not taken from software");

  a_idle_line_high: assert property (
    @(posedge clk) disable iff (!arst_n)
    (s.txSt == spz_pkg::TX_IDLE) |-> serialOutPin)
    else $error("serial output low while idle");

  a_sync_no_async: assert property (
    @(posedge clk) disable iff (!arst_n)
    (clkEn && isSync) |=> s.rxSt == spz_pkg::RX_IDLE)
    else $error("asynchronous receiver runs in shift mode");

  a_sync_rx_start: assert property (
    @(posedge clk) disable iff (!arst_n)
    (clkEn && isSync && s.txSt == spz_pkg::TX_IDLE && s.ren && !s.ri &&
     s.rxSt == spz_pkg::RX_IDLE && !busReq) |=>
      (s.txSt == spz_pkg::TX_SHIFT && s.m0Rx))
    else $error("shift mode reception did not start");

  a_oe_only_sync: assert property (
    @(posedge clk) disable iff (!arst_n)
    serialInOe |-> $past(isSync))
    else $error("data pin driven outside shift mode");

  a_sync_clock_rise: assert property (
    @(posedge clk) disable iff (!arst_n)
    ($rose(serialOutPin) && isSync && $past(isSync)) |->
      (s.m0Ph == 4'h0 || s.txSt == spz_pkg::TX_IDLE))
    else $error("shift clock rose at wrong phase");

endmodule : spz_serial_port
`default_nettype wire

// ==== test/spz_remote_uart.sv ====
// remote 9-bit asynchronous transceiver facing the serial port
`timescale 1ns/1ps
`default_nettype none
module spz_remote_uart #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk, // same clock as the port
  input wire logic lineIn, // port serial output
  output logic lineOut, // port serial input, idles high
  input wire logic sendReq, // one-cycle request to send
  input wire logic [8:0] sendWord, // ninth bit and data byte
  output logic gotValid, // one-cycle pulse, frame captured
  output logic [10:0] gotFrame // stop, ninth, data, start
);
  initial begin
    lineOut = 1'b1;
    gotValid = 1'b0;
    gotFrame = '0;
  end
  ////////////////////////////////////////////////////////////////////////
  // send: start low, data lsb first, ninth, stop high
  always @(posedge clk) if (sendReq) begin : tx
    logic [10:0] f;
    f = {1'b1, sendWord, 1'b0};
    for (int i = 0; i < 11; i++) begin
      lineOut <= f[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // receive: on a low line wait half a bit, then sample mid-bit
  always @(posedge clk) if (lineIn === 1'b0) begin : rx
    logic [10:0] f;
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      f[i] = lineIn;
      if (i < 10) repeat (BIT_CLKS) @(posedge clk);
    end
    gotFrame <= f;
    gotValid <= 1'b1;
    @(posedge clk);
    gotValid <= 1'b0;
  end
endmodule : spz_remote_uart
`default_nettype wire

// ==== test/spz_serial_port_tb.sv ====
// self-checking bench of the serial port in the 9-bit fixed-rate mode
`timescale 1ns/1ps
`default_nettype none
`include "spz_map.svh"
module spz_serial_port_tb;
  logic clk, arst_n, wbCyc, wbStb, wbWe, wbAck, wakeReq, outPin;
  logic inOut, inOe, remLine, pinLine, sendReq, gotValid, t, mp;
  logic clkEn, slowPm;
  int wakeCnt = 0;
  logic [9:0] wbAdr;
  logic [31:0] wbDatW, wbDatR;
  logic [8:0] sendWord;
  logic [10:0] gotFrame;
  logic [7:0] b, held;
  logic [7:0] expRd[$], mskRd[$];
  logic [10:0] expLine[$];
  int errorCnt = 0, nChecks = 0, cycles = 0;
  // open-drain data pin: pulled low whenever the port drives it
  assign pinLine = inOe ? 1'b0 : remLine;
  spz_serial_port DUT (.clk(clk), .arst_n(arst_n), .clkEn(clkEn),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
    .wbSel(4'hf), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
    .timer1Ovf(1'b0), .timer2Ovf(1'b0), .slowPowerMode(slowPm),
    .wakeReq(wakeReq), .serialOutPin(outPin), .serialInPin(pinLine),
    .serialInOut(inOut), .serialInOe(inOe));
  spz_remote_uart #(.BIT_CLKS(32)) REM (.clk(clk), .lineIn(outPin),
    .lineOut(remLine), .sendReq(sendReq), .sendWord(sendWord),
    .gotValid(gotValid), .gotFrame(gotFrame));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic reportAndStop();
    if (errorCnt == 0 && nChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : reportAndStop
  task automatic chk(input string nm, input logic [10:0] e,
                     input logic [10:0] g);
    nChecks++;
    if (g !== e) begin
      errorCnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic xfer(input logic [7:0] idx, input logic we,
                      input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {idx, 2'b00};
    wbDatW <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    if (wbAck !== 1'b1) errorCnt++;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask : xfer
  task automatic rd(input logic [7:0] idx, input logic [7:0] e,
                    input logic [7:0] m);
    expRd.push_back(e);
    mskRd.push_back(m);
    xfer(idx, 1'b0, 8'h00);
  endtask : rd
  ////////////////////////////////////////////////////////////////////////
  // watcher: every read answer and every captured frame meets its note
  always @(posedge clk) begin
    cycles++;
    if (wakeReq === 1'b1) wakeCnt++;
    if (cycles == 12000) begin
      errorCnt++;
      reportAndStop();
    end
    if (wbAck === 1'b1 && wbWe === 1'b0 && expRd.size() > 0) begin
      chk("read", {3'h0, expRd[0] & mskRd[0]}, {3'h0, wbDatR[7:0] & mskRd[0]});
      void'(expRd.pop_front());
      void'(mskRd.pop_front());
    end
    if (gotValid === 1'b1 && expLine.size() > 0)
      chk("frame", expLine.pop_front(), gotFrame);
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    b = 8'($urandom(36));
    {arst_n, wbCyc, wbStb, wbWe, sendReq, slowPm} = '0;
    clkEn = 1'b1;
    {wbAdr, wbDatW, sendWord} = '0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    rd(`SPZ_IDX_CTRL, 8'h00, 8'hff);
    rd(`SPZ_IDX_AUX, 8'h00, 8'h07);
    rd(8'h10, 8'h00, 8'hff);
    xfer(`SPZ_IDX_AUX, 1'b1, 8'h01);
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      t = i[0];
      xfer(`SPZ_IDX_CTRL, 1'b1, {4'h8, t, 3'h0});
      expLine.push_back({1'b1, t, b, 1'b0});
      xfer(`SPZ_IDX_DATA, 1'b1, b);
      repeat (400) @(posedge clk);
      rd(`SPZ_IDX_CTRL, {4'h8, t, 3'b010}, 8'hff);
    end
    held = 8'h00;
    slowPm <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      mp = (i > 0);
      t = (i != 1);
      b = 8'($urandom);
      xfer(`SPZ_IDX_CTRL, 1'b1, {2'b10, mp, 5'h10});
      @(posedge clk);
      sendReq <= 1'b1;
      sendWord <= {t, b};
      @(posedge clk);
      sendReq <= 1'b0;
      repeat (420) @(posedge clk);
      if (!mp || t) begin
        held = b;
        rd(`SPZ_IDX_CTRL, {2'b10, mp, 5'h15}, 8'hff);
      end
      else rd(`SPZ_IDX_CTRL, {2'b10, mp, 5'h10}, 8'hfb);
      rd(`SPZ_IDX_DATA, held, 8'hff);
    end
    chk("wake", 11'h1, 11'(wakeCnt > 0));
    slowPm <= 1'b0;
    expLine.push_back({2'b10, ~held, 1'b0});
    xfer(`SPZ_IDX_DATA, 1'b1, ~held);
    rd(`SPZ_IDX_DATA, held, 8'hff);
    repeat (400) @(posedge clk);
    chk("pending", 11'h0, 11'(expLine.size()));
    reportAndStop();
  end
endmodule : spz_serial_port_tb
`default_nettype wire
